// >>> pkg/sdoc_consts.vh
`ifndef SDOC_CONSTS_VH
`define SDOC_CONSTS_VH
`define SDOC_ACC_W 40
`define SDOC_POS_MAX 24'h7F_FFFF
`define SDOC_NEG_MAX 24'h80_0000
`define SDOC_WIDTH_16 2'h0
`define SDOC_WIDTH_24 2'h1
`define SDOC_WIDTH_32S 2'h2
`define SDOC_WIDTH_32 2'h3
`define SDOC_WIDTH_RST 2'h1
`define SDOC_NCH 3
`endif

// >>> hw/sdoc_buf2.v
`timescale 1ns/100ps
// two-entry skid buffer, read data from registers
module sdoc_buf2
#(
    parameter W = 96
)
(
    input wire core_clk,
    input wire sys_rst,
    input wire inValid,
    output wire inReady,
    input wire [W-1:0] inData,
    output wire outValid,
    input wire outReady,
    output reg [W-1:0] outData
);
reg [W-1:0] spare;
reg [1:0] count;
wire push;
wire pop;
assign inReady = (count != 2'h2);
assign outValid = (count != 2'h0);
assign push = inValid && inReady;
assign pop = outValid && outReady;

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        count <= 2'h0;
        outData <= {W{1'b0}};
        spare <= {W{1'b0}};
    end
    else
    begin
        if (push && !pop)
            count <= count + 2'h1;
        else if (pop && !push)
            count <= count - 2'h1;
        if (pop)
        begin
            if (count == 2'h2)
                outData <= spare;
            else if (push)
                outData <= inData;
        end
        else if (push)
        begin
            if (count == 2'h0)
                outData <= inData;
            else
                spare <= inData;
        end
        if (push && pop && count == 2'h2)
            spare <= inData;
    end
end
endmodule // sdoc_buf2

// >>> hw/sdoc_decimator.v
`timescale 1ns/100ps
`include "sdoc_consts.vh"
// three-channel sinc3 + sinc1 decimator with output coding
module sdoc_decimator
(
    input wire core_clk,
    input wire sys_rst,
    input wire sampleEnable,
    input wire [2:0] bitstreamIn,
    input wire [2:0] oversamplingSelect,
    input wire [1:0] outputWidthSelect,
    input wire extReferenceSelect,
    output wire useInternalReference,
    output wire outputRateClock,
    output wire dataValid,
    input wire dataReady,
    output wire [95:0] dataWords,
    output wire [4:0] resolutionBits,
    output wire overflowLost
);
localparam AW = `SDOC_ACC_W;

//////////////////////////////////////////////////////////////////////////////
// ratio decode
function [9:0] cubicRatio;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: cubicRatio = 10'd32;
            3'h1: cubicRatio = 10'd64;
            3'h2: cubicRatio = 10'd128;
            3'h3: cubicRatio = 10'd256;
            default: cubicRatio = 10'd512;
        endcase
    end
endfunction

function [3:0] avgRatio;
    input [2:0] sel;
    begin
        case (sel)
            3'h5: avgRatio = 4'd2;
            3'h6: avgRatio = 4'd4;
            3'h7: avgRatio = 4'd8;
            default: avgRatio = 4'd1;
        endcase
    end
endfunction

// log2 of cubic ratio cubed, for normalising the sinc3 gain
function [5:0] cubicShift;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: cubicShift = 6'd15;
            3'h1: cubicShift = 6'd18;
            3'h2: cubicShift = 6'd21;
            3'h3: cubicShift = 6'd24;
            default: cubicShift = 6'd27;
        endcase
    end
endfunction

function [4:0] resBits;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: resBits = 5'd17;
            3'h1: resBits = 5'd20;
            3'h2: resBits = 5'd23;
            default: resBits = 5'd24;
        endcase
    end
endfunction

// scale average to 24-bit full scale, clamp, left-justify
function [23:0] codeResult;
    input [AW-1:0] sum;
    input [5:0] shift;
    input [4:0] res;
    reg [AW-1:0] scaled;
    reg [23:0] clamped;
    reg [23:0] mask;
    begin
        // bitstream 1/0 maps to +1/-1, full scale 2^23 after shift
        if (shift >= 6'd23)
            scaled = $signed(sum) >>> (shift - 6'd23);
        else
            scaled = sum << (6'd23 - shift);
        if ($signed(scaled) > $signed({{(AW-24){1'b0}}, `SDOC_POS_MAX}))
            clamped = `SDOC_POS_MAX;
        else if ($signed(scaled) < $signed({{(AW-24){1'b1}}, `SDOC_NEG_MAX}))
            clamped = `SDOC_NEG_MAX;
        else
            clamped = scaled[23:0];
        mask = 24'hFF_FFFF << (5'd24 - res);
        codeResult = clamped & mask;
    end
endfunction

function [31:0] formatWord;
    input [23:0] r;
    input [1:0] w;
    begin
        case (w)
            `SDOC_WIDTH_16: formatWord = {16'h0000, r[23:8]};
            `SDOC_WIDTH_32S: formatWord = {{8{r[23]}}, r};
            `SDOC_WIDTH_32: formatWord = {r, 8'h00};
            default: formatWord = {8'h00, r};
        endcase
    end
endfunction

//////////////////////////////////////////////////////////////////////////////
// configuration and pacing
reg [2:0] selLatched;
reg [9:0] phaseCount;
reg [3:0] avgCount;
reg [3:0] outputsSeen;
reg rateTick;
reg [AW-1:0] integ1 [0:2];
reg [AW-1:0] integ2 [0:2];
reg [AW-1:0] integ3 [0:2];
reg [AW-1:0] diff1 [0:2];
reg [AW-1:0] diff2 [0:2];
reg [AW-1:0] diff3 [0:2];
reg [AW-1:0] avgSum [0:2];
reg [AW-1:0] next_integ1 [0:2];
reg [AW-1:0] next_integ2 [0:2];
reg [AW-1:0] next_integ3 [0:2];
reg [AW-1:0] sincOut [0:2];
reg [AW-1:0] next_avgSum [0:2];
reg [95:0] pendWords;
reg pendValid;
reg [1:0] widthSel;
wire bufReady;
wire [9:0] cubicNow;
wire [3:0] avgNow;
wire cubicDone;
wire avgDone;
wire [3:0] settleOutputs;
wire [5:0] avgShift;
integer ch;
integer cc;

assign cubicNow = cubicRatio(selLatched);
assign avgNow = avgRatio(selLatched);
assign cubicDone = sampleEnable && (phaseCount == cubicNow - 10'd1);
assign avgDone = cubicDone && (avgCount == avgNow - 4'd1);
// sinc3 outputs needed: settling = (3 + avg - 1) * cubic
assign settleOutputs = 4'd2 + avgNow;
// log2 of the averaging ratio, added to the sinc3 gain shift
assign avgShift = {4'h0, avgNow[3] | avgNow[2], avgNow[3] | avgNow[1]};
assign useInternalReference = ~extReferenceSelect;
assign outputRateClock = rateTick;
assign resolutionBits = resBits(selLatched);

// unpipelined integrators so the comb sees the sample of this edge and
// the first settled sinc3 output is exact
always @*
begin
    for (cc = 0; cc < `SDOC_NCH; cc = cc + 1)
    begin
        next_integ1[cc] = integ1[cc] + (bitstreamIn[cc] ?
            {{(AW-1){1'b0}}, 1'b1} : {AW{1'b1}});
        next_integ2[cc] = integ2[cc] + next_integ1[cc];
        next_integ3[cc] = integ3[cc] + next_integ2[cc];
        sincOut[cc] = ((next_integ3[cc] - diff1[cc]) - diff2[cc]) - diff3[cc];
        next_avgSum[cc] = (avgCount == 4'd0) ? sincOut[cc] :
            avgSum[cc] + sincOut[cc];
    end
end

//////////////////////////////////////////////////////////////////////////////
// filters
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        selLatched <= 3'h0;
        widthSel <= `SDOC_WIDTH_RST;
        phaseCount <= 10'd0;
        avgCount <= 4'd0;
        outputsSeen <= 4'd0;
        rateTick <= 1'b0;
        pendWords <= 96'h0;
        pendValid <= 1'b0;
        for (ch = 0; ch < `SDOC_NCH; ch = ch + 1)
        begin
            integ1[ch] <= {AW{1'b0}};
            integ2[ch] <= {AW{1'b0}};
            integ3[ch] <= {AW{1'b0}};
            diff1[ch] <= {AW{1'b0}};
            diff2[ch] <= {AW{1'b0}};
            diff3[ch] <= {AW{1'b0}};
            avgSum[ch] <= {AW{1'b0}};
        end
    end
    else
    begin
        rateTick <= avgDone;
        if (pendValid && bufReady)
            pendValid <= 1'b0;
        if (sampleEnable)
        begin
            phaseCount <= cubicDone ? 10'd0 : phaseCount + 10'd1;
            for (ch = 0; ch < `SDOC_NCH; ch = ch + 1)
            begin
                // integrators at sample rate, input +1/-1
                integ1[ch] <= next_integ1[ch];
                integ2[ch] <= next_integ2[ch];
                integ3[ch] <= next_integ3[ch];
            end
        end
        if (cubicDone)
        begin
            avgCount <= avgDone ? 4'd0 : avgCount + 4'd1;
            if (outputsSeen != settleOutputs)
                outputsSeen <= outputsSeen + 4'd1;
            for (ch = 0; ch < `SDOC_NCH; ch = ch + 1)
            begin
                // combs at decimated rate
                diff1[ch] <= next_integ3[ch];
                diff2[ch] <= next_integ3[ch] - diff1[ch];
                diff3[ch] <= (next_integ3[ch] - diff1[ch]) - diff2[ch];
                avgSum[ch] <= next_avgSum[ch];
            end
        end
        // emit only settled results, one per rate period
        if (avgDone && (outputsSeen + 4'd1) >= settleOutputs)
        begin
            pendValid <= 1'b1;
            for (ch = 0; ch < `SDOC_NCH; ch = ch + 1)
                pendWords[ch*32 +: 32] <= formatWord(codeResult(
                    next_avgSum[ch], cubicShift(selLatched) + avgShift,
                    resBits(selLatched)), widthSel);
        end
        // settings change only at an output boundary, a ratio change restarting settling
        if (avgDone || phaseCount == 10'd0 && avgCount == 4'd0 &&
            (selLatched != oversamplingSelect))
        begin
            widthSel <= outputWidthSelect;
            if (selLatched != oversamplingSelect)
            begin
                selLatched <= oversamplingSelect;
                outputsSeen <= 4'd0;
                phaseCount <= 10'd0;
                // averaging window opens on the third sinc3 output
                avgCount <= (avgRatio(oversamplingSelect) == 4'd1) ? 4'd0 :
                    avgRatio(oversamplingSelect) - 4'd2;
            end
        end
    end
end

assign overflowLost = pendValid && !bufReady;

//////////////////////////////////////////////////////////////////////////////
// output buffer
sdoc_buf2 #(.W(96)) outBuf
(
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(pendValid),
    .inReady(bufReady),
    .inData(pendWords),
    .outValid(dataValid),
    .outReady(dataReady),
    .outData(dataWords)
);
endmodule // sdoc_decimator

// >>> dv/sdoc_checker.sv
`timescale 1ns/100ps
module sdoc_checker
(
    input wire core_clk,
    input wire sys_rst,
    input wire sampleEnable,
    input wire [1:0] outputWidthSelect,
    input wire extReferenceSelect,
    input wire useInternalReference,
    input wire outputRateClock,
    input wire dataValid,
    input wire dataReady,
    input wire [95:0] dataWords,
    input wire [4:0] resolutionBits,
    input wire overflowLost
);
    wire [23:0] lowMask;
    assign lowMask = (24'h00_0001 << (5'h18 - resolutionBits)) - 24'h00_0001;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    ref_follow_a: assert property (useInternalReference == !extReferenceSelect)
        else $error("reference select not followed");
    reset_clear_a: assert property ($fell(sys_rst) |-> !dataValid && dataWords == 96'h0 && !outputRateClock)
        else $error("outputs not cleared by reset");
    low_zero_a: assert property (dataValid && outputWidthSelect == 2'h1 |-> (dataWords[23:0] & lowMask) == 24'h00_0000)
        else $error("unused low bits not zero");
    orc_pulse_a: assert property (outputRateClock |=> !outputRateClock)
        else $error("rate pulse longer than one cycle");
    orc_sample_a: assert property (outputRateClock |-> $past(sampleEnable))
        else $error("rate pulse without final sample");
    valid_orc_a: assert property ($rose(dataValid) |-> $past(outputRateClock))
        else $error("data valid without rate pulse");
    hold_word_a: assert property (dataValid && !dataReady |=> dataValid && $stable(dataWords))
        else $error("word changed while stalled");
    lost_full_a: assert property (overflowLost |-> dataValid)
        else $error("overflow with empty buffer");
    sign_ext_a: assert property (dataValid && outputWidthSelect == 2'h2 |-> dataWords[31:24] == {8{dataWords[23]}})
        else $error("sign extension wrong");
    cover property (dataValid && dataReady);
    cover property (overflowLost);
    cover property (outputRateClock);
endmodule // sdoc_checker
bind sdoc_decimator sdoc_checker u_sdoc_checker(.core_clk, .sys_rst,
    .sampleEnable, .outputWidthSelect, .extReferenceSelect,
    .useInternalReference, .outputRateClock, .dataValid, .dataReady,
    .dataWords, .resolutionBits, .overflowLost);

// >>> dv/sdoc_mod_model.sv
`timescale 1ns/100ps
// modulator source, one sample every third cycle, plus stallable consumer
module sdoc_mod_model
(
    input wire core_clk,
    input wire run,
    input wire stall,
    input wire [2:0] bits,
    output reg sampleEnable,
    output reg [2:0] bitstreamIn,
    output reg dataReady,
    output integer nSamples
);
    integer ph;
    initial
    begin
        sampleEnable = 1'b0;
        bitstreamIn = 3'h0;
        dataReady = 1'b0;
        nSamples = 0;
        ph = 0;
    end
    always @(negedge core_clk)
    begin
        ph <= (!run || ph == 2) ? 0 : ph + 1;
        sampleEnable <= run && ph == 0;
        nSamples <= !run ? 0 : nSamples + (ph == 0);
        // bits between samples are junk on purpose
        bitstreamIn <= (run && ph == 0) ? bits : ~bitstreamIn;
        dataReady <= !stall;
    end
endmodule // sdoc_mod_model

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
    reg core_clk, sys_rst, run, stall, extReferenceSelect;
    reg [2:0] oversamplingSelect, bits;
    reg [1:0] outputWidthSelect;
    wire sampleEnable, useInternalReference, outputRateClock;
    wire dataValid, dataReady, overflowLost;
    wire [2:0] bitstreamIn;
    wire [95:0] dataWords;
    wire [4:0] resolutionBits;
    integer nSamples, n_mismatch, cmp_count, i, k, n, tot, st;
    integer cubT [0:7] = '{32, 64, 128, 256, 512, 512, 512, 512};
    integer avgT [0:7] = '{1, 1, 1, 1, 1, 2, 4, 8};
    integer resT [0:7] = '{17, 20, 23, 24, 24, 24, 24, 24};
    reg [1:0] widT [0:7] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2};
    reg [2:0] bitT [0:7] = '{3'h7, 3'h0, 3'h5, 3'h2, 3'h3, 3'h4, 3'h6, 3'h1};
    sdoc_decimator u_sdoc_decimator(.core_clk, .sys_rst, .sampleEnable,
        .bitstreamIn, .oversamplingSelect, .outputWidthSelect,
        .extReferenceSelect, .useInternalReference, .outputRateClock,
        .dataValid, .dataReady, .dataWords, .resolutionBits, .overflowLost);
    sdoc_mod_model u_sdoc_mod_model(.core_clk, .run, .stall, .bits,
        .sampleEnable, .bitstreamIn, .dataReady, .nSamples);
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function [31:0] fmt(input b, input integer res, input [1:0] w);
        reg [23:0] r;
        begin
            r = b ? 24'h7F_FFFF & ~((24'h00_0001 << (24 - res)) - 24'h00_0001)
                : 24'h80_0000;
            fmt = w == 2'h0 ? {16'h0000, r[23:8]} : w == 2'h1 ? {8'h00, r}
                : w == 2'h2 ? {{8{r[23]}}, r} : {r, 8'h00};
        end
    endfunction
    task chk_num(input integer got, input integer exp);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
            end
        end
    endtask
    task chk_val(input [31:0] got, input [31:0] exp, input [31:0] m);
        begin
            cmp_count++;
            if ((got & m) !== exp)
            begin
                n_mismatch++;
                $display("[FAIL] %0t value %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wait_valid;
        begin
            k = 0;
            while (dataValid !== 1'b1 && k < 20000)
            begin
                @(negedge core_clk);
                k++;
            end
            chk_num(k < 20000, 1);
        end
    endtask
    task do_reset;
        begin
            sys_rst = 1'b1;
            run <= 1'b0;
            repeat (4) @(negedge core_clk);
            sys_rst = 1'b0;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #4_500_000;
        n_mismatch++;
        stop_test;
    end
    initial
    begin
        {n_mismatch, cmp_count, stall, extReferenceSelect} = 0;
        {sys_rst, run, oversamplingSelect, bits} = {1'b1, 7'h00};
        outputWidthSelect = 2'h1;
        for (i = 0; i < 8; i++)
        begin
            oversamplingSelect = i;
            outputWidthSelect = widT[i];
            bits = bitT[i];
            do_reset;
            run <= 1'b1;
            tot = cubT[i] * avgT[i];
            st = (2 + avgT[i]) * cubT[i];
            wait_valid;
            chk_num(nSamples, st);
            chk_val(resolutionBits, resT[i], 32'h0000_001F);
            for (n = 0; n < 3; n++)
                chk_val(dataWords[32*n+:32], fmt(bitT[i][n], resT[i], widT[i]),
                    widT[i] == 2'h0 ? 32'h0000_FFFF : widT[i] == 2'h1 ?
                    32'h00FF_FFFF : 32'hFFFF_FFFF);
            @(negedge core_clk);
            wait_valid;
            chk_num(nSamples, st + tot);
            $display("row %0d done", i);
        end
        {oversamplingSelect, outputWidthSelect, bits, stall} = 9'h0_0F;
        do_reset;
        run <= 1'b1;
        for (k = 0; overflowLost !== 1'b1 && k < 4000; k++)
            @(negedge core_clk);
        chk_val(overflowLost, 1, 1);
        stall <= 1'b0;
        n = 0;
        repeat (10)
        begin
            @(negedge core_clk);
            #1 n += (dataValid === 1'b1 && dataReady === 1'b1);
        end
        chk_num(n, 3);
        chk_val(dataValid, 0, 1);
        $display("overflow test done");
        @(negedge core_clk);
        stall <= 1'b1;
        wait_valid;
        sys_rst = 1'b1;
        @(negedge core_clk);
        chk_val(dataValid, 0, 1);
        chk_val(dataWords[95:64] | dataWords[63:32] | dataWords[31:0], 0,
            32'hFFFF_FFFF);
        sys_rst = 1'b0;
        for (n = 0; n < 2; n++)
        begin
            @(negedge core_clk);
            extReferenceSelect = n;
            #1 chk_val(useInternalReference, !n, 1);
        end
        $display("reset and reference tests done");
        stop_test;
    end
endmodule // tb
